// ===== src/qa_watchdog_status_and_init.sv
/*
  status reporting and initialization of the question-and-answer watchdog.
  assumes all event strobes are one-cycle pulses from logic on clock_i; multi-answer
  evaluation arrives as a finished cycle outcome, single-answer evaluation is done here.
*/
`timescale 1ns/1ns
module qa_watchdog_status_and_init
  import qa_wd_pkg::*;
(
  // clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          reset_i,
  // initialization events
  input  wire logic                          reset_to_diag_i,
  input  wire logic                          diag_to_active_i,
  input  wire logic                          safe_to_diag_i,
  input  wire logic                          self_test_done_i,
  // configuration writes
  input  wire logic                          mode_select_wr_i,
  input  wire logic                          mode_select_wdata_i,
  input  wire logic                          window_one_wr_i,
  input  wire logic                          window_two_wr_i,
  input  wire logic                          question_setup_wr_i,
  input  wire logic [qa_wd_pkg::CFG_W-1:0]   cfg_wdata_i,
  input  wire logic                          enable_drive_th_wr_i,
  input  wire logic                          reset_th_wr_i,
  input  wire logic [qa_wd_pkg::CNT_W-1:0]   th_wdata_i,
  input  wire logic                          config_changed_clr_i,
  // answers and windows
  input  wire logic                          answer_valid_i,
  input  wire logic                          answer_correct_i,
  input  wire logic                          window_one_end_i,
  input  wire logic                          window_two_end_i,
  // multi-answer cycle outcome
  input  wire logic                          multi_cycle_end_i,
  input  wire logic [qa_wd_pkg::FLAG_N-1:0]  multi_flags_i,
  // status read
  input  wire logic                          status_read_i,
  // status and configuration
  output logic      [qa_wd_pkg::FLAG_N-1:0]  status_flags_o,
  output logic      [qa_wd_pkg::FLAG_N-1:0]  status_rdata_o,
  output logic                               watchdog_failure_flag_o,
  output logic                               config_changed_flag_o,
  output logic                               answer_mode_select_o,
  output logic      [qa_wd_pkg::ANS_W-1:0]   answer_countdown_o,
  output logic      [qa_wd_pkg::CNT_W-1:0]   failure_counter_o,
  output logic      [qa_wd_pkg::CNT_W-1:0]   enable_drive_fail_threshold_o,
  output logic      [qa_wd_pkg::CNT_W-1:0]   reset_fail_threshold_o,
  output logic      [qa_wd_pkg::Q_W-1:0]     current_question_o,
  output logic      [qa_wd_pkg::CFG_W-1:0]   question_setup_register_o,
  output logic      [qa_wd_pkg::CFG_W-1:0]   response_window_one_length_o,
  output logic      [qa_wd_pkg::CFG_W-1:0]   response_window_two_length_o,
  output logic                               new_cycle_o
);
  typedef struct packed {
    phase_t            phase;
    logic              closed_seen;
    logic              closed_ok;
    logic              open_seen;
    logic              open_ok;
    logic              mode;
    logic              cfg_chg;
    logic              watchdog_failure_flag;
    logic [ANS_W-1:0]  countdown;
    logic [CNT_W-1:0]  endrv_th;
    logic [CNT_W-1:0]  rst_th;
    logic [Q_W-1:0]    question;
    logic [Q_W-1:0]    engine;
    logic [CFG_W-1:0]  qsetup;
    logic [CFG_W-1:0]  win1;
    logic [CFG_W-1:0]  win2;
    logic              new_cycle;
  } wd_state_t;

  wd_state_t s_q;
  wd_state_t s_d;

  // event decode
  logic              mode_change;
  logic              cfg_write;
  logic              full_init;
  logic              part_init;
  logic              init_any;
  logic              next_mode;
  // derived terms
  logic              state_move;
  logic              status_update;
  logic              question_reinit;
  logic              clean_cycle;
  logic              fail_above;
  logic [Q_W-1:0]    engine_step;
  logic [ANS_W-1:0]  count_init;
  logic [ANS_W-1:0]  count_reload;
  // cycle outcome
  logic              cyc_end;
  logic [FLAG_N-1:0] cyc_flags;
  logic              fc_load;
  logic [CNT_W-1:0]  fc_load_val;
  logic              fc_inc;
  logic              fc_dec;
  logic [CNT_W-1:0]  fail_count;

  assign mode_change = mode_select_wr_i && (mode_select_wdata_i != s_q.mode);
  assign cfg_write   = window_one_wr_i || window_two_wr_i || question_setup_wr_i;
  assign full_init   = reset_to_diag_i || mode_change;
  assign state_move  = diag_to_active_i || safe_to_diag_i;
  assign part_init   = state_move || self_test_done_i;
  assign init_any    = full_init || cfg_write || part_init;
  assign next_mode   = reset_to_diag_i ? MODE_RESET : (mode_change ? mode_select_wdata_i : s_q.mode);
  assign question_reinit = full_init || self_test_done_i;
  assign status_update   = cyc_end && !init_any;
  assign clean_cycle     = cyc_end && (cyc_flags == FLAGS_CLEAR);
  assign fail_above      = fail_count > s_q.endrv_th;
  assign engine_step     = {s_q.engine[Q_W-2:0], s_q.engine[Q_W-1] ^ s_q.engine[Q_W-2] ^ 1'b1};

  // cycle outcome, single mode evaluated from answers and windows
  always_comb begin
    cyc_end   = 1'b0;
    cyc_flags = FLAGS_CLEAR;
    if (s_q.mode == MODE_MULTI) begin
      cyc_end   = multi_cycle_end_i;
      cyc_flags = multi_flags_i;
    end else if (s_q.phase == PH_CLOSED && window_one_end_i && s_q.closed_seen) begin
      cyc_end                = 1'b1;
      cyc_flags[FLAG_EARLY]  = 1'b1;
      cyc_flags[FLAG_WRONG]  = !s_q.closed_ok;
    end else if (s_q.phase == PH_OPEN && window_two_end_i) begin
      cyc_end = 1'b1;
      if (s_q.open_seen) begin
        cyc_flags[FLAG_WRONG] = !s_q.open_ok;
      end else begin
        cyc_flags[FLAG_TIMEOUT] = 1'b1;
      end
    end
  end

  // countdown start values per mode
  always_comb begin
    count_init   = ANS_INIT_SING;
    count_reload = ANS_INIT_SING;
    if (next_mode == MODE_MULTI) begin
      count_init = ANS_INIT_MULTI;
    end
    if (s_q.mode == MODE_MULTI) begin
      count_reload = ANS_INIT_MULTI;
    end
  end

  // failure counter steering, broadest init first
  always_comb begin
    fc_load     = 1'b0;
    fc_load_val = FAIL_INIT;
    fc_inc      = 1'b0;
    fc_dec      = 1'b0;
    if (full_init) begin
      fc_load = 1'b1;
    end else if (part_init) begin
      fc_load     = 1'b1;
      fc_load_val = s_q.endrv_th;
    end else if (cfg_write) begin
      fc_inc = 1'b1;
    end else if (cyc_end) begin
      fc_inc = !clean_cycle;
      fc_dec = clean_cycle;
    end
  end

  always_comb begin
    s_d           = s_q;
    s_d.new_cycle = 1'b0;
    // answer countdown in either mode, single mode window tracking
    if (answer_valid_i) begin
      if (s_q.countdown != '0) begin
        s_d.countdown = s_q.countdown - 2'h1;
      end
      if (s_q.phase == PH_CLOSED && !s_q.closed_seen) begin
        s_d.closed_seen = 1'b1;
        s_d.closed_ok   = answer_correct_i;
      end else if (s_q.phase == PH_OPEN && !s_q.open_seen) begin
        s_d.open_seen = 1'b1;
        s_d.open_ok   = answer_correct_i;
      end
    end
    // empty closed window opens the second one
    if (s_q.phase == PH_CLOSED && window_one_end_i && !s_q.closed_seen) begin
      s_d.phase = PH_OPEN;
    end
    // failure flag set once counter goes above threshold, held until init
    if (!s_q.watchdog_failure_flag && fail_above) begin
      s_d.watchdog_failure_flag = 1'b1;
    end
    // finished cycle restarts with same or new question
    if (cyc_end) begin
      s_d.new_cycle   = 1'b1;
      s_d.phase       = PH_CLOSED;
      s_d.closed_seen = 1'b0;
      s_d.open_seen   = 1'b0;
      s_d.countdown   = count_reload;
      if (clean_cycle) begin
        s_d.engine   = engine_step;
        s_d.question = engine_step;
      end
    end
    // configuration writes hold their values
    if (window_one_wr_i) begin
      s_d.win1 = cfg_wdata_i;
    end
    if (window_two_wr_i) begin
      s_d.win2 = cfg_wdata_i;
    end
    if (question_setup_wr_i) begin
      s_d.qsetup = cfg_wdata_i;
    end
    if (enable_drive_th_wr_i) begin
      s_d.endrv_th = th_wdata_i;
    end
    if (reset_th_wr_i) begin
      s_d.rst_th = th_wdata_i;
    end
    if (config_changed_clr_i) begin
      s_d.cfg_chg = 1'b0;
    end
    // initialization, union of coinciding events
    s_d.mode = next_mode;
    if (init_any) begin
      s_d.new_cycle   = 1'b1;
      s_d.phase       = PH_CLOSED;
      s_d.closed_seen = 1'b0;
      s_d.open_seen   = 1'b0;
      s_d.watchdog_failure_flag     = 1'b0;
      s_d.countdown   = count_init;
    end
    if (mode_change || cfg_write) begin
      s_d.cfg_chg = 1'b1;
    end
    if (question_reinit) begin
      s_d.question = QUESTION_INIT;
      s_d.engine   = QUESTION_INIT;
    end
    if (full_init) begin
      s_d.qsetup   = QSETUP_INIT;
      s_d.win1     = WIN1_INIT;
      s_d.win2     = WIN2_INIT;
      s_d.endrv_th = ENDRV_TH_INIT;
      s_d.rst_th   = RST_TH_INIT;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q          <= '0;
      s_q.phase    <= PH_CLOSED;
      s_q.mode     <= MODE_RESET;
      s_q.countdown <= ANS_INIT_MULTI;
      s_q.cfg_chg  <= 1'b0;
      s_q.watchdog_failure_flag  <= 1'b0;
      s_q.new_cycle <= 1'b0;
      s_q.endrv_th <= ENDRV_TH_INIT;
      s_q.rst_th   <= RST_TH_INIT;
      s_q.question <= QUESTION_INIT;
      s_q.engine   <= QUESTION_INIT;
      s_q.qsetup   <= QSETUP_INIT;
      s_q.win1     <= WIN1_INIT;
      s_q.win2     <= WIN2_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  wd_status_latch u_status (
    .clock_i  (clock_i),
    .reset_i  (reset_i),
    .init_i   (init_any),
    .update_i (status_update),
    .flags_i  (cyc_flags),
    .read_i   (status_read_i),
    .flags_o  (status_flags_o),
    .rdata_o  (status_rdata_o)
  );

  watchdog_failure_flag_counter u_fail (
    .clock_i    (clock_i),
    .reset_i    (reset_i),
    .load_i     (fc_load),
    .load_val_i (fc_load_val),
    .inc_i      (fc_inc),
    .dec_i      (fc_dec),
    .count_o    (fail_count)
  );

  assign failure_counter_o             = fail_count;
  assign watchdog_failure_flag_o       = s_q.watchdog_failure_flag;
  assign config_changed_flag_o         = s_q.cfg_chg;
  assign answer_mode_select_o          = s_q.mode;
  assign answer_countdown_o            = s_q.countdown;
  assign enable_drive_fail_threshold_o = s_q.endrv_th;
  assign reset_fail_threshold_o        = s_q.rst_th;
  assign current_question_o            = s_q.question;
  assign question_setup_register_o     = s_q.qsetup;
  assign response_window_one_length_o  = s_q.win1;
  assign response_window_two_length_o  = s_q.win2;
  assign new_cycle_o                   = s_q.new_cycle;
endmodule : qa_watchdog_status_and_init

// ===== src/qa_wd_pkg.sv
/*
  constants, state type and defaults for the question-and-answer watchdog status and init logic.
  assumes one clock domain and event strobes that are single-cycle pulses from logic on that clock.
*/
package qa_wd_pkg;

  localparam int CFG_W = 8;
  localparam int CNT_W = 4;
  localparam int ANS_W = 2;
  localparam int Q_W   = 4;

  // status flag bit positions
  localparam int FLAG_TIMEOUT = 0;
  localparam int FLAG_SEQ     = 1;
  localparam int FLAG_EARLY   = 2;
  localparam int FLAG_WRONG   = 3;
  localparam int FLAG_N       = 4;

  localparam logic              MODE_MULTI     = 1'h0;
  localparam logic              MODE_SINGLE    = 1'h1;
  localparam logic              MODE_RESET     = 1'h0;
  localparam logic [ANS_W-1:0]  ANS_INIT_MULTI = 2'h3;
  localparam logic [ANS_W-1:0]  ANS_INIT_SING  = 2'h1;
  localparam logic [CNT_W-1:0]  FAIL_INIT      = 4'h5;
  localparam logic [CNT_W-1:0]  ENDRV_TH_INIT  = 4'h5;
  localparam logic [CNT_W-1:0]  RST_TH_INIT    = 4'hF;
  localparam logic [CNT_W-1:0]  CNT_MAX        = 4'hF;
  localparam logic [CNT_W-1:0]  CNT_MIN        = 4'h0;
  localparam logic [Q_W-1:0]    QUESTION_INIT  = 4'h0;
  localparam logic [CFG_W-1:0]  QSETUP_INIT    = 8'h00;
  localparam logic [CFG_W-1:0]  WIN1_INIT      = 8'h00;
  localparam logic [CFG_W-1:0]  WIN2_INIT      = 8'h00;
  localparam logic [FLAG_N-1:0] FLAGS_CLEAR    = 4'h0;

  typedef enum logic [1:0] {
    PH_CLOSED = 2'h0,
    PH_OPEN   = 2'h1
  } phase_t;

endpackage : qa_wd_pkg

// ===== src/wd_status_latch.sv
/*
  latched watchdog status flags with clear-on-read.
  assumes update, read and init are one-cycle pulses on clock_i.
*/
`timescale 1ns/1ns
module wd_status_latch
  import qa_wd_pkg::*;
(
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      reset_i,
  // control
  input  wire logic                      init_i,
  input  wire logic                      update_i,
  input  wire logic [qa_wd_pkg::FLAG_N-1:0] flags_i,
  input  wire logic                      read_i,
  // status
  output logic      [qa_wd_pkg::FLAG_N-1:0] flags_o,
  output logic      [qa_wd_pkg::FLAG_N-1:0] rdata_o
);
  typedef struct packed {
    logic [FLAG_N-1:0] flags;
    logic [FLAG_N-1:0] rdata;
  } latch_state_t;

  latch_state_t s_q;
  latch_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (read_i) begin
      s_d.rdata = s_q.flags;
    end
    if (init_i) begin
      s_d.flags = FLAGS_CLEAR;
    end else if (update_i) begin
      s_d.flags = flags_i;
    end else if (read_i) begin
      s_d.flags = FLAGS_CLEAR;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flags_o = s_q.flags;
  assign rdata_o = s_q.rdata;
endmodule : wd_status_latch

// ===== src/watchdog_failure_flag_counter.sv
/*
  saturating watchdog failure counter with load, increment and decrement.
  assumes load outranks increment, increment outranks decrement.
*/
`timescale 1ns/1ns
module watchdog_failure_flag_counter
  import qa_wd_pkg::*;
(
  // clock and reset
  input  wire logic                     clock_i,
  input  wire logic                     reset_i,
  // control
  input  wire logic                     load_i,
  input  wire logic [qa_wd_pkg::CNT_W-1:0] load_val_i,
  input  wire logic                     inc_i,
  input  wire logic                     dec_i,
  // count
  output logic      [qa_wd_pkg::CNT_W-1:0] count_o
);
  typedef struct packed {
    logic [CNT_W-1:0] count;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (load_i) begin
      s_d.count = load_val_i;
    end else if (inc_i) begin
      if (s_q.count != CNT_MAX) begin
        s_d.count = s_q.count + 4'h1;
      end
    end else if (dec_i) begin
      if (s_q.count != CNT_MIN) begin
        s_d.count = s_q.count - 4'h1;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_q.count <= FAIL_INIT;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;
endmodule : watchdog_failure_flag_counter

// ===== bench/qa_wd_props.sv
/*
  assertions on the watchdog status and init ports.
  assumes event strobes are one-cycle pulses on clock_i.
*/
`timescale 1ns/1ns
module qa_wd_props
  import qa_wd_pkg::*;
(
  // clock and reset
  input wire logic                            clock_i,
  input wire logic                            reset_i,
  // events and writes
  input wire logic                            reset_to_diag_i,
  input wire logic                            diag_to_active_i,
  input wire logic                            safe_to_diag_i,
  input wire logic                            self_test_done_i,
  input wire logic                            mode_select_wr_i,
  input wire logic                            mode_select_wdata_i,
  input wire logic                            window_one_wr_i,
  input wire logic                            window_two_wr_i,
  input wire logic                            question_setup_wr_i,
  input wire logic                            enable_drive_th_wr_i,
  // cycle ends and read
  input wire logic                            window_one_end_i,
  input wire logic                            window_two_end_i,
  input wire logic                            multi_cycle_end_i,
  input wire logic                            status_read_i,
  // outputs watched
  input wire logic [qa_wd_pkg::FLAG_N-1:0]    status_flags_o,
  input wire logic [qa_wd_pkg::FLAG_N-1:0]    status_rdata_o,
  input wire logic                            watchdog_failure_flag_o,
  input wire logic                            config_changed_flag_o,
  input wire logic                            answer_mode_select_o,
  input wire logic [qa_wd_pkg::ANS_W-1:0]     answer_countdown_o,
  input wire logic [qa_wd_pkg::CNT_W-1:0]     failure_counter_o,
  input wire logic [qa_wd_pkg::CNT_W-1:0]     enable_drive_fail_threshold_o,
  input wire logic [qa_wd_pkg::CNT_W-1:0]     reset_fail_threshold_o,
  input wire logic                            new_cycle_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  // event classes
  wire mchg = mode_select_wr_i && (mode_select_wdata_i != answer_mode_select_o);
  wire full = reset_to_diag_i || mchg;
  wire cfgw = window_one_wr_i || window_two_wr_i || question_setup_wr_i;
  wire part = diag_to_active_i || safe_to_diag_i || self_test_done_i;
  wire any  = full || cfgw || part;
  wire ends = window_one_end_i || window_two_end_i || multi_cycle_end_i;
  a_init_clear: assert property (
    any |=> status_flags_o == 4'h0 && !watchdog_failure_flag_o) else $error("init left flags set");
  a_count_init: assert property (
    any |=> answer_countdown_o == (answer_mode_select_o ? 2'h1 : 2'h3)) else $error("countdown init wrong");
  a_full_defaults: assert property (
    full |=> failure_counter_o == 4'h5 && enable_drive_fail_threshold_o == 4'h5 && reset_fail_threshold_o == 4'hF)
    else $error("full init values wrong");
  a_part_load: assert property (
    part && !full && !enable_drive_th_wr_i |=> failure_counter_o == $past(enable_drive_fail_threshold_o))
    else $error("counter not loaded from threshold");
  a_cfg_inc: assert property (
    cfgw && !full && !part |=> failure_counter_o ==
      ($past(failure_counter_o) == 4'hF ? 4'hF : $past(failure_counter_o) + 4'h1)) else $error("no increment");
  a_chg_set: assert property (
    mchg || cfgw |=> config_changed_flag_o) else $error("config changed flag not set");
  a_mode_clear: assert property (
    reset_to_diag_i && !mode_select_wr_i |=> !answer_mode_select_o) else $error("mode not cleared");
  a_read_clear: assert property (
    status_read_i && !ends && !any |=> status_rdata_o == $past(status_flags_o) && status_flags_o == 4'h0)
    else $error("read did not return and clear");
  a_flags_hold: assert property (
    !status_read_i && !ends && !any |=> $stable(status_flags_o)) else $error("flags moved mid cycle");
  a_new_cycle: assert property (
    any |=> new_cycle_o) else $error("no new cycle after init");
  c_full: cover property (full);
  c_part: cover property (part);
  c_read: cover property (status_read_i && status_flags_o != 4'h0);
endmodule : qa_wd_props

bind qa_watchdog_status_and_init qa_wd_props props (
  .clock_i(clock_i), .reset_i(reset_i),
  .reset_to_diag_i(reset_to_diag_i), .diag_to_active_i(diag_to_active_i),
  .safe_to_diag_i(safe_to_diag_i), .self_test_done_i(self_test_done_i),
  .mode_select_wr_i(mode_select_wr_i), .mode_select_wdata_i(mode_select_wdata_i),
  .window_one_wr_i(window_one_wr_i), .window_two_wr_i(window_two_wr_i),
  .question_setup_wr_i(question_setup_wr_i), .enable_drive_th_wr_i(enable_drive_th_wr_i),
  .window_one_end_i(window_one_end_i), .window_two_end_i(window_two_end_i),
  .multi_cycle_end_i(multi_cycle_end_i), .status_read_i(status_read_i),
  .status_flags_o(status_flags_o), .status_rdata_o(status_rdata_o),
  .watchdog_failure_flag_o(watchdog_failure_flag_o), .config_changed_flag_o(config_changed_flag_o),
  .answer_mode_select_o(answer_mode_select_o), .answer_countdown_o(answer_countdown_o),
  .failure_counter_o(failure_counter_o), .enable_drive_fail_threshold_o(enable_drive_fail_threshold_o),
  .reset_fail_threshold_o(reset_fail_threshold_o), .new_cycle_o(new_cycle_o)
);

// ===== bench/wd_mcu_model.sv
/*
  mcu model that sends watchdog answers.
  assumes the bench calls answer from its main thread.
*/
`timescale 1ns/1ns
module wd_mcu_model (
  // clock
  input  wire logic clock_i,
  // answer
  output logic      answer_valid_o,
  output logic      answer_correct_o
);
  initial begin
    answer_valid_o = 1'b0;
    answer_correct_o = 1'b0;
  end
  // one answer after dly cycles, qualifier inverted when idle
  task automatic answer(input logic ok, input int dly);
    repeat (dly) @(negedge clock_i);
    answer_valid_o = 1'b1;
    answer_correct_o = ok;
    @(negedge clock_i);
    answer_valid_o = 1'b0;
    answer_correct_o = ~ok;
  endtask : answer
endmodule : wd_mcu_model

// ===== bench/qa_watchdog_status_and_init_bench.sv
/*
  self-checking bench for the watchdog status and init block.
  assumes strobes are driven on falling edges, one cycle each.
*/
`timescale 1ns/1ns
module qa_watchdog_status_and_init_bench;
  import qa_wd_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [14:0] s = 15'h0000;
  logic mode_select_wdata_i = 1'b0;
  logic [CFG_W-1:0] cfg_wdata_i = 8'h00;
  logic [CNT_W-1:0] th_wdata_i = 4'h0;
  logic [FLAG_N-1:0] multi_flags_i = 4'h0;
  logic answer_valid_i, answer_correct_i;
  logic [FLAG_N-1:0] status_flags_o, status_rdata_o;
  logic watchdog_failure_flag_o, config_changed_flag_o, answer_mode_select_o, new_cycle_o;
  logic [ANS_W-1:0] answer_countdown_o;
  logic [CNT_W-1:0] failure_counter_o, enable_drive_fail_threshold_o, reset_fail_threshold_o;
  logic [Q_W-1:0] current_question_o;
  logic [CFG_W-1:0] question_setup_register_o, response_window_one_length_o, response_window_two_length_o;
  int n_errors = 0;
  int check_count = 0;
  int seed = 32'h18B031E4;
  logic [CNT_W-1:0] fc, th;
  logic [Q_W-1:0] q;
  logic [CFG_W-1:0] d;
  localparam int RTD = 0, MWR = 4, E1 = 11, E2 = 12, ME = 13, RD = 14;

  qa_watchdog_status_and_init DUT (
    .clock_i(clock_i), .reset_i(reset_i),
    .mode_select_wdata_i(mode_select_wdata_i), .cfg_wdata_i(cfg_wdata_i), .th_wdata_i(th_wdata_i),
    .answer_valid_i(answer_valid_i), .answer_correct_i(answer_correct_i), .multi_flags_i(multi_flags_i),
    .status_flags_o(status_flags_o), .status_rdata_o(status_rdata_o), .new_cycle_o(new_cycle_o),
    .watchdog_failure_flag_o(watchdog_failure_flag_o), .config_changed_flag_o(config_changed_flag_o),
    .answer_mode_select_o(answer_mode_select_o), .answer_countdown_o(answer_countdown_o),
    .failure_counter_o(failure_counter_o), .enable_drive_fail_threshold_o(enable_drive_fail_threshold_o),
    .reset_fail_threshold_o(reset_fail_threshold_o), .current_question_o(current_question_o),
    .question_setup_register_o(question_setup_register_o),
    .response_window_one_length_o(response_window_one_length_o),
    .response_window_two_length_o(response_window_two_length_o),
    .reset_to_diag_i(s[0]), .diag_to_active_i(s[1]), .safe_to_diag_i(s[2]),
    .self_test_done_i(s[3]), .mode_select_wr_i(s[4]), .window_one_wr_i(s[5]),
    .window_two_wr_i(s[6]), .question_setup_wr_i(s[7]), .enable_drive_th_wr_i(s[8]),
    .reset_th_wr_i(s[9]), .config_changed_clr_i(s[10]), .window_one_end_i(s[11]),
    .window_two_end_i(s[12]), .multi_cycle_end_i(s[13]), .status_read_i(s[14])
  );
  wd_mcu_model mcu (.clock_i, .answer_valid_o(answer_valid_i), .answer_correct_o(answer_correct_i));

  always #2 clock_i = ~clock_i;

  function automatic logic [CNT_W-1:0] step(input logic [CNT_W-1:0] v, input logic up);
    if (up) return (v == 4'hF) ? v : v + 4'h1;
    return (v == 4'h0) ? v : v - 4'h1;
  endfunction : step

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic fire(input int a, input int b = -1);
    @(negedge clock_i);
    s[a] = 1'b1;
    if (b >= 0) s[b] = 1'b1;
    @(negedge clock_i);
    s = 15'h0000;
  endtask : fire

  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (3000) @(posedge clock_i);
    n_errors++;
    stop_test;
  end

  initial begin
    repeat (8) @(negedge clock_i);
    reset_i = 1'b0;
    chk(8'(answer_countdown_o), 8'h03);
    chk(8'(failure_counter_o), 8'h05);
    chk(8'(reset_fail_threshold_o), 8'h0F);
    chk(8'(answer_mode_select_o), 8'h00);
    $display("reset test done");
    // state transitions and self test
    th = 4'($random(seed));
    th_wdata_i = th;
    fire(8, 9);
    for (int i = 1; i < 4; i++) begin
      q = current_question_o;
      fire(i);
      chk(8'(new_cycle_o), 8'h01);
      chk(8'(failure_counter_o), 8'(th));
      chk(8'(config_changed_flag_o), 8'h00);
      chk(8'(answer_countdown_o), 8'h03);
      if (i < 3) chk(8'(current_question_o), 8'(q));
    end
    chk(8'(reset_fail_threshold_o), 8'(th));
    $display("transition test done");
    // window and question writes
    fc = th;
    for (int i = 5; i < 8; i++) begin
      d = 8'($random(seed));
      cfg_wdata_i = d;
      fire(i);
      fc = step(fc, 1'b1);
      chk(8'(failure_counter_o), 8'(fc));
      chk(8'(config_changed_flag_o), 8'h01);
      chk(i == 5 ? response_window_one_length_o : i == 6 ? response_window_two_length_o
          : question_setup_register_o, d);
    end
    chk(8'(enable_drive_fail_threshold_o), 8'(th));
    $display("config write test done");
    // mode change to single answer
    mode_select_wdata_i = 1'b1;
    fire(MWR);
    chk(8'(answer_countdown_o), 8'h01);
    chk(8'(failure_counter_o), 8'h05);
    chk(8'(enable_drive_fail_threshold_o), 8'h05);
    chk(8'(reset_fail_threshold_o), 8'h0F);
    chk(response_window_one_length_o, WIN1_INIT);
    fire(10);
    fire(MWR);
    chk(8'(config_changed_flag_o), 8'h00);
    $display("mode test done");
    // open window wrong answer, then read back
    fire(E1);
    mcu.answer(1'b0, 2);
    chk(8'(status_flags_o), 8'h00);
    fire(E2);
    chk(8'(status_flags_o), 8'h08);
    chk(8'(failure_counter_o), 8'h06);
    chk(8'(current_question_o), 8'(QUESTION_INIT));
    @(negedge clock_i);
    chk(8'(watchdog_failure_flag_o), 8'h01);
    fire(RD);
    chk(8'(status_rdata_o), 8'h08);
    chk(8'(status_flags_o), 8'h00);
    fire(RD);
    chk(8'(status_rdata_o), 8'h00);
    fire(E1);
    fire(E2);
    chk(8'(status_flags_o), 8'h01);
    mcu.answer(1'b1, 1);
    fire(E1);
    chk(8'(status_flags_o), 8'h04);
    fire(E1);
    mcu.answer(1'b1, 1);
    fire(E2);
    chk(8'(status_flags_o), 8'h00);
    chk(8'(failure_counter_o), 8'h07);
    fire(1);
    chk(8'(status_flags_o), 8'h00);
    chk(8'(watchdog_failure_flag_o), 8'h00);
    chk(8'(failure_counter_o), 8'h05);
    chk(8'(answer_countdown_o), 8'h01);
    $display("single answer test done");
    // coinciding events
    fire(RTD, 5);
    chk(8'(failure_counter_o), 8'h05);
    chk(8'(answer_mode_select_o), 8'h00);
    chk(8'(answer_countdown_o), 8'h03);
    chk(8'(config_changed_flag_o), 8'h01);
    $display("coincide test done");
    // multi answer outcomes
    fc = 4'h5;
    for (int i = 0; i < 12; i++) begin
      multi_flags_i = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : 4'($random(seed));
      fire(ME);
      fc = step(fc, multi_flags_i != 4'h0);
      chk(8'(status_flags_o), 8'(multi_flags_i));
      chk(8'(failure_counter_o), 8'(fc));
    end
    $display("multi answer test done");
    q = current_question_o;
    fire(2);
    chk(8'(current_question_o), 8'(q));
    fire(3);
    chk(8'(current_question_o), 8'(QUESTION_INIT));
    $display("question test done");
    stop_test;
  end
endmodule : qa_watchdog_status_and_init_bench
